// ### hdl/pfc_pkg.sv
// constants, command codes and operation type for the flash controller
// assumes one 125 MHz clock and an asynchronous 64K x 16 parallel flash

package pfc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 125;
  localparam int T_ACC_NS    = 45;
  localparam int T_WP_NS     = 40;
  localparam int T_SU_NS     = 10;
  localparam int T_NOISE_NS  = 15;
  localparam int SYNC_STAGES = 2;
  localparam int ACC_CYC     = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC      = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int SU_CYC      = (T_SU_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_CYC      = ACC_CYC + SYNC_STAGES + 1;
  localparam int POLL_MAX    = 2000000;

  // ----------------------------------------------------------------
  // command codes and addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'hAAA;
  localparam logic [7:0]  DAT_UNLOCK1  = 8'hAA;
  localparam logic [7:0]  DAT_UNLOCK2  = 8'h55;
  localparam logic [7:0]  CODE_PROG    = 8'hA0;
  localparam logic [7:0]  CODE_ERASE   = 8'h80;
  localparam logic [7:0]  CODE_ID_IN   = 8'h90;
  localparam logic [7:0]  CODE_ID_OUT  = 8'hF0;
  localparam logic [7:0]  CODE_CHIP    = 8'h10;
  localparam logic [7:0]  CODE_MAIN    = 8'h30;
  localparam logic [7:0]  CODE_LOCK    = 8'h40;
  localparam logic [15:0] ADDR_LOCK_ST = 16'h0002;
  localparam logic [15:0] ADDR_BOOT_HI = 16'h1FFF;
  localparam logic [15:0] ADDR_ERASE_POLL = 16'h0000;
  localparam int          TOGGLE_POS   = 6;
  localparam int          POLL_POS     = 7;
  localparam int          LOCK_POS     = 0;

  typedef enum logic [2:0] {
    OP_READ,
    OP_PROG,
    OP_CHIP_ERASE,
    OP_MAIN_ERASE,
    OP_LOCKOUT,
    OP_ID_ENTRY,
    OP_ID_EXIT
  } pfc_op_t;

endpackage

// ### hdl/pfc_bus_cycle.sv
// one asynchronous read or write cycle on the flash pins
// assumes start only while idle; data input is asynchronous to clock
`timescale 1ns/1ns

module pfc_bus_cycle
  import pfc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  output logic [15:0]      flash_addr,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic [15:0]      flash_dq_o,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_i
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} pfc_bst_t;

  typedef struct packed {
    pfc_bst_t    st;
    logic [3:0]  cnt;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] dq_o;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        done;
    logic [15:0] rdata;
    logic [15:0] sync1;
    logic [15:0] sync2;
  } pfc_bus_t;

  pfc_bus_t q_ff;
  pfc_bus_t nxt_q;

  always_comb
  begin
    nxt_q       = q_ff;
    nxt_q.done  = 1'b0;
    nxt_q.sync1 = flash_dq_i;
    nxt_q.sync2 = q_ff.sync1;
    unique case (q_ff.st)
      B_IDLE:
      begin
        if (start)
        begin
          nxt_q.wr    = is_write;
          nxt_q.addr  = addr;
          nxt_q.ce_n  = 1'b0;
          nxt_q.dq_o  = wdata;
          nxt_q.dq_oe = is_write;
          nxt_q.cnt   = 4'(SU_CYC - 1);
          nxt_q.st    = B_SETUP;
        end
      end
      B_SETUP:
      begin
        if (q_ff.cnt == 4'h0)
        begin
          // write never overlaps output enable
          nxt_q.we_n = !q_ff.wr;
          nxt_q.oe_n = q_ff.wr;
          // strobe is held well past the noise filter
          nxt_q.cnt  = q_ff.wr ? 4'(WP_CYC - 1) : 4'(RD_CYC - 1);
          nxt_q.st   = B_STROBE;
        end
        else
          nxt_q.cnt = q_ff.cnt - 4'h1;
      end
      B_STROBE:
      begin
        if (q_ff.cnt == 4'h0)
        begin
          nxt_q.we_n = 1'b1;
          nxt_q.oe_n = 1'b1;
          if (!q_ff.wr)
            nxt_q.rdata = q_ff.sync2;
          nxt_q.cnt = 4'(SU_CYC - 1);
          nxt_q.st  = B_HOLD;
        end
        else
          nxt_q.cnt = q_ff.cnt - 4'h1;
      end
      B_HOLD:
      begin
        // data kept past the rising strobe so the device latches it
        if (q_ff.cnt == 4'h0)
        begin
          nxt_q.ce_n  = 1'b1;
          nxt_q.dq_oe = 1'b0;
          nxt_q.done  = 1'b1;
          nxt_q.st    = B_IDLE;
        end
        else
          nxt_q.cnt = q_ff.cnt - 4'h1;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      q_ff      <= '0;
      q_ff.ce_n <= 1'b1;
      q_ff.oe_n <= 1'b1;
      q_ff.we_n <= 1'b1;
    end
    else if (clk_en)
      q_ff <= nxt_q;
  end

  assign done        = q_ff.done;
  assign rdata       = q_ff.rdata;
  assign flash_addr  = q_ff.addr;
  assign flash_ce_n  = q_ff.ce_n;
  assign flash_oe_n  = q_ff.oe_n;
  assign flash_we_n  = q_ff.we_n;
  assign flash_dq_o  = q_ff.dq_o;
  assign flash_dq_oe = q_ff.dq_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst || !clk_en);

  no_contend_a: assert property (q_ff.dq_oe |-> q_ff.oe_n)
    else $error("host drives data while output enable is low");
  read_frame_a: assert property (!q_ff.oe_n |-> !q_ff.ce_n && q_ff.we_n)
    else $error("read strobe outside a selected read");
  wr_inhibit_a: assert property (!q_ff.we_n |-> !q_ff.ce_n && q_ff.oe_n)
    else $error("write strobe while inhibited");
  we_width_a: assert property ($fell(q_ff.we_n) |->
    (!q_ff.we_n)[*5] ##1 q_ff.we_n)
    else $error("write pulse width wrong");
  data_hold_a: assert property ($rose(q_ff.we_n) |->
    q_ff.dq_oe && $stable(q_ff.dq_o))
    else $error("data not held at rising write strobe");

endmodule

// ### hdl/pfc_ctrl.sv
// host-side command sequencer for a 64K x 16 parallel flash
// assumes the flash pins are wired to the bus-cycle instance below
`timescale 1ns/1ns

module pfc_ctrl
  import pfc_pkg::*;
#(
  parameter int POLL_LIMIT = pfc_pkg::POLL_MAX
)
(
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             clk_en,
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  wire pfc_pkg::pfc_op_t cmd_op,
  input  wire logic [15:0]      cmd_addr,
  input  wire logic [15:0]      cmd_wdata,
  output logic                  rsp_valid,
  output logic [15:0]           rsp_rdata,
  output logic                  rsp_timeout,
  output logic [15:0]           flash_addr,
  output logic                  flash_ce_n,
  output logic                  flash_oe_n,
  output logic                  flash_we_n,
  output logic [15:0]           flash_dq_o,
  output logic                  flash_dq_oe,
  input  wire logic [15:0]      flash_dq_i
);

  // ----------------------------------------------------------------
  // sequence tables
  // ----------------------------------------------------------------
  localparam int PW = $clog2(POLL_LIMIT + 1);

  function automatic logic [2:0] seq_len(input pfc_op_t op);
    unique case (op)
      OP_READ:     seq_len = 3'd1;
      OP_PROG:     seq_len = 3'd4;
      OP_ID_ENTRY: seq_len = 3'd3;
      OP_ID_EXIT:  seq_len = 3'd1;
      default:     seq_len = 3'd6;
    endcase
  endfunction

  function automatic logic needs_poll(input pfc_op_t op);
    needs_poll = (op == OP_PROG) || (op == OP_CHIP_ERASE) ||
                 (op == OP_MAIN_ERASE) || (op == OP_LOCKOUT);
  endfunction

  // returns {address, data} for one write of a command sequence
  function automatic logic [31:0] step_word(input pfc_op_t     op,
                                            input logic [2:0]  step,
                                            input logic [15:0] a,
                                            input logic [15:0] d);
    logic [7:0] code;
    code = 8'h00;
    step_word = '0;
    if (op == OP_ID_EXIT)
      step_word = {4'h0, ADDR_UNLOCK1, 8'h00, CODE_ID_OUT};
    else if (op == OP_PROG && step == 3'd3)
      step_word = {a, d};
    else
    begin
      unique case (step)
        3'd0, 3'd3:
          step_word = {4'h0, ADDR_UNLOCK1, 8'h00, DAT_UNLOCK1};
        3'd1, 3'd4:
          step_word = {4'h0, ADDR_UNLOCK2, 8'h00, DAT_UNLOCK2};
        3'd2:
        begin
          code = (op == OP_PROG) ? CODE_PROG :
                 (op == OP_ID_ENTRY) ? CODE_ID_IN : CODE_ERASE;
          step_word = {4'h0, ADDR_UNLOCK1, 8'h00, code};
        end
        default:
        begin
          code = (op == OP_CHIP_ERASE) ? CODE_CHIP :
                 (op == OP_MAIN_ERASE) ? CODE_MAIN : CODE_LOCK;
          step_word = {4'h0, ADDR_UNLOCK1, 8'h00, code};
        end
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_POLL_ISSUE, S_POLL_WAIT, S_DONE
  } pfc_st_t;

  typedef struct packed {
    pfc_st_t     st;
    pfc_op_t     op;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [2:0]  step;
    logic [PW-1:0] polls;
    logic        prev_tgl;
    logic        have_prev;
    logic        ready;
    logic        rsp_valid;
    logic [15:0] rsp_rdata;
    logic        rsp_timeout;
    logic        bus_start;
    logic        bus_wr;
    logic [15:0] bus_addr;
    logic [15:0] bus_data;
  } pfc_ctl_t;

  pfc_ctl_t    q_ff;
  pfc_ctl_t    nxt_q;
  logic        bus_done;
  logic [15:0] bus_rdata;

  always_comb
  begin
    nxt_q           = q_ff;
    nxt_q.bus_start = 1'b0;
    nxt_q.rsp_valid = 1'b0;
    unique case (q_ff.st)
      S_IDLE:
      begin
        if (cmd_valid && q_ff.ready)
        begin
          nxt_q.op          = cmd_op;
          nxt_q.addr        = cmd_addr;
          nxt_q.wdata       = cmd_wdata;
          nxt_q.step        = 3'd0;
          nxt_q.ready       = 1'b0;
          nxt_q.rsp_timeout = 1'b0;
          nxt_q.st          = S_ISSUE;
        end
      end
      S_ISSUE:
      begin
        nxt_q.bus_start = 1'b1;
        nxt_q.bus_wr    = (q_ff.op != OP_READ);
        if (q_ff.op == OP_READ)
          {nxt_q.bus_addr, nxt_q.bus_data} = {q_ff.addr, 16'h0000};
        else
          {nxt_q.bus_addr, nxt_q.bus_data} =
            step_word(q_ff.op, q_ff.step, q_ff.addr, q_ff.wdata);
        nxt_q.st = S_WAIT;
      end
      S_WAIT:
      begin
        if (bus_done)
        begin
          if (q_ff.op == OP_READ)
          begin
            nxt_q.rsp_rdata = bus_rdata;
            nxt_q.st        = S_DONE;
          end
          else if (q_ff.step == seq_len(q_ff.op) - 3'd1)
          begin
            // timed operations are watched before the next access
            nxt_q.polls     = '0;
            nxt_q.have_prev = 1'b0;
            nxt_q.st = needs_poll(q_ff.op) ? S_POLL_ISSUE : S_DONE;
          end
          else
          begin
            nxt_q.step = q_ff.step + 3'd1;
            nxt_q.st   = S_ISSUE;
          end
        end
      end
      S_POLL_ISSUE:
      begin
        nxt_q.bus_start = 1'b1;
        nxt_q.bus_wr    = 1'b0;
        nxt_q.bus_addr  = (q_ff.op == OP_PROG) ? q_ff.addr : ADDR_ERASE_POLL;
        nxt_q.bus_data  = 16'h0000;
        nxt_q.st        = S_POLL_WAIT;
      end
      S_POLL_WAIT:
      begin
        if (bus_done)
        begin
          // two equal toggle bits in a row mean the operation ended
          if (q_ff.have_prev && q_ff.prev_tgl == bus_rdata[TOGGLE_POS])
          begin
            nxt_q.rsp_rdata = bus_rdata;
            nxt_q.st        = S_DONE;
          end
          else if (q_ff.polls == PW'(POLL_LIMIT - 1))
          begin
            nxt_q.rsp_rdata   = bus_rdata;
            nxt_q.rsp_timeout = 1'b1;
            nxt_q.st          = S_DONE;
          end
          else
          begin
            nxt_q.prev_tgl  = bus_rdata[TOGGLE_POS];
            nxt_q.have_prev = 1'b1;
            nxt_q.polls     = q_ff.polls + PW'(1);
            nxt_q.st        = S_POLL_ISSUE;
          end
        end
      end
      S_DONE:
      begin
        nxt_q.rsp_valid = 1'b1;
        nxt_q.ready     = 1'b1;
        nxt_q.st        = S_IDLE;
      end
      default:
        nxt_q.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      q_ff       <= '0;
      q_ff.ready <= 1'b1;
    end
    else if (clk_en)
      q_ff <= nxt_q;
  end

  assign cmd_ready   = q_ff.ready;
  assign rsp_valid   = q_ff.rsp_valid;
  assign rsp_rdata   = q_ff.rsp_rdata;
  assign rsp_timeout = q_ff.rsp_timeout;

  // ----------------------------------------------------------------
  // pin cycles
  // ----------------------------------------------------------------
  pfc_bus_cycle u_bus (
    .clock       (clock),
    .srst        (srst),
    .clk_en      (clk_en),
    .start       (q_ff.bus_start),
    .is_write    (q_ff.bus_wr),
    .addr        (q_ff.bus_addr),
    .wdata       (q_ff.bus_data),
    .done        (bus_done),
    .rdata       (bus_rdata),
    .flash_addr  (flash_addr),
    .flash_ce_n  (flash_ce_n),
    .flash_oe_n  (flash_oe_n),
    .flash_we_n  (flash_we_n),
    .flash_dq_o  (flash_dq_o),
    .flash_dq_oe (flash_dq_oe),
    .flash_dq_i  (flash_dq_i)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst || !clk_en);

  logic cmd_wr;
  assign cmd_wr = q_ff.bus_start && q_ff.bus_wr && q_ff.op != OP_ID_EXIT;

  unlock_one_a: assert property (cmd_wr && q_ff.step == 3'd0 |->
    q_ff.bus_addr[11:0] == ADDR_UNLOCK1 &&
    q_ff.bus_data[7:0] == DAT_UNLOCK1)
    else $error("first unlock write wrong");
  unlock_two_a: assert property (cmd_wr && q_ff.step == 3'd1 |->
    q_ff.bus_addr[11:0] == ADDR_UNLOCK2 &&
    q_ff.bus_data[7:0] == DAT_UNLOCK2)
    else $error("second unlock write wrong");
  third_code_a: assert property (cmd_wr && q_ff.step == 3'd2 &&
    q_ff.op == OP_PROG |-> q_ff.bus_data[7:0] == CODE_PROG)
    else $error("program code wrong");
  sixth_main_a: assert property (cmd_wr && q_ff.step == 3'd5 &&
    q_ff.op == OP_MAIN_ERASE |-> q_ff.bus_addr[11:0] == ADDR_UNLOCK1 &&
    q_ff.bus_data[7:0] == CODE_MAIN)
    else $error("main erase final write wrong");
  upper_zero_a: assert property (cmd_wr &&
    !(q_ff.op == OP_PROG && q_ff.step == 3'd3) |->
    q_ff.bus_addr[15:12] == 4'h0 && q_ff.bus_data[15:8] == 8'h00)
    else $error("command upper bits not zero");
  exit_single_a: assert property (q_ff.bus_start && q_ff.op == OP_ID_EXIT
    |-> q_ff.bus_wr && q_ff.bus_data[7:0] == CODE_ID_OUT ##1
    q_ff.st == S_WAIT)
    else $error("identification exit write wrong");
  busy_block_a: assert property (q_ff.st != S_IDLE |-> !cmd_ready)
    else $error("new command accepted while busy");
  poll_first_a: assert property (q_ff.st == S_WAIT && bus_done &&
    needs_poll(q_ff.op) && q_ff.step == seq_len(q_ff.op) - 3'd1 |->
    ##1 q_ff.st == S_POLL_ISSUE ##1 q_ff.bus_start && !q_ff.bus_wr)
    else $error("completion not polled after program or erase");

  read_rsp_c: cover property (q_ff.op == OP_READ && rsp_valid);
  prog_rsp_c: cover property (q_ff.op == OP_PROG && rsp_valid &&
    !rsp_timeout);
  erase_rsp_c: cover property (q_ff.op == OP_CHIP_ERASE && rsp_valid);
  timeout_c: cover property (rsp_valid && rsp_timeout);

endmodule

// ### verification/pfc_flash_model.sv
// ----------------------------------------------------------------
// behavioural model of the 64K x 16 parallel flash
// ----------------------------------------------------------------
// assumes the controller's split data pins; resolves the data wire itself
`timescale 1ns/1ns

module pfc_flash_model #(
  parameter int          PROG_NS  = 600,
  parameter int          ERASE_NS = 1500,
  parameter logic [15:0] MFR_CODE = 16'h00A5, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h005C  // arbitrary value
)
(
  input  wire logic [15:0] address_lines,
  input  wire logic        chip_select_n,
  input  wire logic        output_drive_enable_n,
  input  wire logic        write_strobe_n,
  input  wire logic [15:0] host_dq,
  input  wire logic        host_dq_oe,
  output logic [15:0]      data_lines
);
  localparam int NOISE_NS = 15;
  logic [15:0] mem [0:65535];
  logic [15:0] la, ld, last, rd;
  logic        busy, tog, idm, locked;
  int          step, dur;
  time         tfall;
  wire ws  = chip_select_n | write_strobe_n;
  wire drv = !chip_select_n && !output_drive_enable_n &&
             write_strobe_n;

  initial
  begin
    for (int i = 0; i < 65536; i++) mem[i] = i[15:0] ^ 16'h5A5A;
    {busy, tog, idm, locked} = 4'h0;
    step = 0;
    last = 16'h0000;
    ld = 16'hFFFF;
  end

  task automatic start(input logic [15:0] d, input int ns);
    ld = d;
    dur = ns;
    busy = 1'b1;
  endtask

  task automatic erase(input logic all_blocks);
    for (int i = 0; i < 65536; i++)
      if (i > 16'h1FFF || (all_blocks && !locked))
        mem[i] = 16'hFFFF;
    start(16'hFFFF, ERASE_NS);
  endtask

  task automatic cmd(input logic [15:0] a, input logic [15:0] d);
    logic [11:0] a12;
    logic [7:0]  d8;
    a12 = a[11:0];
    d8 = d[7:0];
    case (step)
      0: if (d8 == 8'hF0) idm = 1'b0;
         else step = (a12 == 12'h555 && d8 == 8'hAA) ? 1 : 0;
      1: step = ((a12 == 12'hAAA || a12 == 12'h2AA) && d8 == 8'h55)
           ? 2 : 0;
      2:
      begin
        step = 0;
        if (a12 == 12'h555)
          case (d8)
            8'hA0: step = 9;
            8'h80: step = 3;
            8'h90: idm = 1'b1;
            8'hF0: idm = 1'b0;
            default: step = 0;
          endcase
      end
      3: step = (a12 == 12'h555 && d8 == 8'hAA) ? 4 : 0;
      4: step = (a12 == 12'hAAA && d8 == 8'h55) ? 5 : 0;
      5:
      begin
        step = 0;
        if (a12 == 12'h555)
          case (d8)
            8'h10: erase(1'b1);
            8'h30: erase(1'b0);
            8'h40: begin locked = 1'b1; start(16'hFFFF, PROG_NS); end
            default: step = 0;
          endcase
      end
      9:
      begin
        step = 0;
        if (!(locked && a <= 16'h1FFF)) mem[a] = mem[a] & d;
        start(d, PROG_NS);
      end
      default: step = 0;
    endcase
  endtask

  always @(negedge ws)
  begin
    tfall = $time;
    la = address_lines;
  end

  // too-short pulses, reads and timed work all block the command path
  always @(posedge ws)
    if (!busy && output_drive_enable_n &&
        $time - tfall >= NOISE_NS)
      cmd(la, host_dq);

  always @(posedge busy)
  begin
    #(dur);
    busy = 1'b0;
  end

  always @(negedge output_drive_enable_n)
    if (!chip_select_n && busy) tog = ~tog;

  always @*
  begin
    if (busy) rd = {ld[15:8], ~ld[7], tog, ld[5:0]};
    else if (idm && address_lines == 16'h0000) rd = MFR_CODE;
    else if (idm && address_lines == 16'h0001) rd = DEV_CODE;
    else if (idm && address_lines == 16'h0002) rd = {15'h0000, locked};
    else rd = mem[address_lines];
    if (drv) last = rd;
  end

  // released lines show the inverse of the last driven word
  assign data_lines = host_dq_oe ? host_dq : (drv ? rd : ~last);
endmodule

// ### verification/parallel_flash_command_interface_test.sv
// ----------------------------------------------------------------
// self-checking bench for the flash command controller
// ----------------------------------------------------------------
// assumes pfc_ctrl with a short poll limit and the flash model
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module parallel_flash_command_interface_test;
  import pfc_pkg::*;
  logic        clock, srst, clk_en, cmd_valid, cmd_ready;
  pfc_op_t     cmd_op;
  logic [15:0] cmd_addr, cmd_wdata, rsp_rdata, flash_addr, flash_dq_o;
  logic [15:0] flash_dq_i;
  logic        rsp_valid, rsp_timeout, flash_ce_n, flash_oe_n, flash_we_n;
  logic        flash_dq_oe;
  int          bad_count = 0;
  int          n_tests = 0;

  pfc_ctrl #(.POLL_LIMIT(20)) pfc_ctrl_inst (
    .clock(clock), .srst(srst), .clk_en(clk_en), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_timeout(rsp_timeout), .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i));

  pfc_flash_model pfc_flash_model_inst (
    .address_lines(flash_addr), .chip_select_n(flash_ce_n),
    .output_drive_enable_n(flash_oe_n), .write_strobe_n(flash_we_n),
    .host_dq(flash_dq_o), .host_dq_oe(flash_dq_oe), .data_lines(flash_dq_i));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [15:0] iv(input logic [15:0] a);
    return a ^ 16'h5A5A;
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic run(input pfc_op_t op, input logic [15:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clock);
    while (cmd_ready !== 1'b1 && n < 1000)
    begin
      @(negedge clock);
      n++;
    end
    `CHK(cmd_ready, 1'b1)
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 5000)
    begin
      @(negedge clock);
      n++;
    end
    `CHK(rsp_valid, 1'b1)
    `CHK(rsp_timeout, 1'b0)
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    run(OP_READ, a, 16'h0000);
    `CHK(rsp_rdata, e)
  endtask

  initial
  begin
    repeat (40000) @(posedge clock);
    bad_count++;
    summarize();
  end

  initial
  begin
    {srst, clk_en, cmd_valid} = 3'b111;
    cmd_op = OP_READ;
    cmd_addr = 16'h0000;
    cmd_wdata = 16'h0000;
    repeat (4) @(posedge clock);
    @(negedge clock);
    `CHK({cmd_ready, flash_ce_n, flash_oe_n, flash_we_n}, 4'hF)
    `CHK(flash_dq_oe, 1'b0)
    // first read taken at the first edge after release, frozen mid-strobe
    srst = 1'b0;
    cmd_addr = 16'h0100;
    @(negedge clock);
    cmd_valid = 1'b0;
    repeat (6) @(negedge clock);
    clk_en = 1'b0;
    repeat (5) @(negedge clock);
    `CHK({flash_ce_n, flash_oe_n, rsp_valid}, 3'b000)
    clk_en = 1'b1;
    wait (rsp_valid === 1'b1);
    @(negedge clock);
    `CHK(rsp_rdata, iv(16'h0100))
    rd(16'h1234, iv(16'h1234));
    rd(16'hFFFF, iv(16'hFFFF));
    $display("test read done");
    run(OP_PROG, 16'h2345, 16'h00F0);
    rd(16'h2345, iv(16'h2345) & 16'h00F0);
    run(OP_PROG, 16'h2345, 16'hFF0F);
    rd(16'h2345, 16'h0000);
    $display("test program done");
    run(OP_ID_ENTRY, 16'h0000, 16'h0000);
    rd(16'h0000, 16'h00A5);
    rd(16'h0001, 16'h005C);
    rd(16'h0002, 16'h0000);
    run(OP_ID_EXIT, 16'h0000, 16'h0000);
    rd(16'h0000, iv(16'h0000));
    $display("test identification done");
    run(OP_MAIN_ERASE, 16'h0000, 16'h0000);
    rd(16'h4000, 16'hFFFF);
    rd(16'h0010, iv(16'h0010));
    rd(16'h2000, 16'hFFFF);
    run(OP_CHIP_ERASE, 16'h0000, 16'h0000);
    rd(16'h0010, 16'hFFFF);
    $display("test erase done");
    run(OP_PROG, 16'h0021, 16'h1234);
    run(OP_LOCKOUT, 16'h0000, 16'h0000);
    run(OP_ID_ENTRY, 16'h0000, 16'h0000);
    rd(16'h0002, 16'h0001);
    run(OP_ID_EXIT, 16'h0000, 16'h0000);
    run(OP_PROG, 16'h0020, 16'h0000);
    rd(16'h0020, 16'hFFFF);
    run(OP_PROG, 16'h3000, 16'h1234);
    rd(16'h3000, 16'h1234);
    run(OP_CHIP_ERASE, 16'h0000, 16'h0000);
    rd(16'h0021, 16'h1234);
    rd(16'h1FFF, 16'hFFFF);
    rd(16'h3000, 16'hFFFF);
    $display("test lockout done");
    summarize();
  end
endmodule
